// ---- core/lwc_wake_config.sv ----
// Purpose: SPI-programmed low-power wake configuration bank with sleep control
// Assumes: SPI mode 0, MSB first, one command per 32-bit frame
// Notes:   Answer to a frame is shifted out during the following frame
//
// Operation
// - 32-bit frame: address, write flag, data
// - Prog comparator keepalive register at 0x12
// - Ground comparator keepalive register at 0x13
// - Keepalive channel: comparator on, no polling current
// - Keepalive channel sampled per low-power tick
// - Prog sleep threshold select register at 0x14
// - Ground sleep threshold select register at 0x15
// - Prog ground channel, bit clear: delta threshold
// - Prog ground channel, bit set: normal threshold
// - Battery channel always uses normal threshold
// - Ground channel: clear delta, set normal
// - Sleep only by command; settings kept
// - First answer after wake flags both high
// - Wake on change only when enabled
`timescale 1ns/1ns
module lwc_wake_config
    import lwc_pkg::*;
#(
    parameter int PROG_N   = PROG_CH,      // Programmable channel count
    parameter int GND_N    = GND_CH,       // Ground-switch channel count
    parameter int TICK_CYC = LPM_TICK_CYC  // Cycles per low-power tick
) (
    // System clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // SPI link
    input  wire logic              sclk,
    input  wire logic              csN,
    input  wire logic              mosi,
    output logic                   miso,
    // Comparator levels from the front end
    input  wire logic [PROG_N-1:0] progLevel,
    input  wire logic [GND_N-1:0]  gndLevel,
    // Channel setup from neighbouring logic
    input  wire logic [PROG_N-1:0] progIsBattery,
    input  wire logic [PROG_N-1:0] progWakeEn,
    input  wire logic [GND_N-1:0]  gndWakeEn,
    input  wire logic              faultSummary,
    input  wire logic              intFlag,
    // Front-end control
    output logic                   lowPowerMode,
    output logic [PROG_N-1:0]      progCompActive,
    output logic [GND_N-1:0]       gndCompActive,
    output logic [PROG_N-1:0]      progPollCurrentEn,
    output logic [GND_N-1:0]       gndPollCurrentEn,
    output logic [PROG_N-1:0]      progThrNormal,
    output logic [GND_N-1:0]       gndThrNormal
);

    ////////////////////////////////////////////////////////////////////////
    // Link domain: frame capture
    logic [5:0]            bitCntQ;      // Bits seen this frame
    logic [30:0]           rxShiftQ;     // Incoming bits
    logic [31:0]           frameWordQ;   // Last complete frame
    logic                  frameTglQ;    // Flips per complete frame
    logic                  misoQ;        // Outgoing bit
    logic [4:0]            txIdx;        // Answer bit for next edge
    logic [DATA_W-1:0]     respQ;        // Answer word, system domain

    // Counter and shift register, cleared while deselected
    always_ff @(posedge sclk or posedge csN) begin
        if (csN) begin
            bitCntQ  <= 6'h00;
            rxShiftQ <= 31'h00000000;
        end else begin
            rxShiftQ <= {rxShiftQ[29:0], mosi};
            // Saturate so bits after the 32nd are ignored
            if (bitCntQ != 6'h20) begin
                bitCntQ <= bitCntQ + 6'h01;
            end
        end
    end

    // Completed 32nd bit publishes the frame; rstn gives the toggle a known start while sclk idles
    always_ff @(posedge sclk or negedge rstn) begin
        if (!rstn) begin
            frameWordQ <= 32'h00000000;
            frameTglQ  <= 1'b0;
        end else if (!csN && bitCntQ == 6'h1f) begin
            frameWordQ <= {rxShiftQ, mosi};
            frameTglQ  <= ~frameTglQ;
        end
    end

    // Answer bit shifted on the falling edge; pad bits are zero
    assign txIdx = 5'h1f - bitCntQ[4:0];
    always_ff @(negedge sclk or posedge csN) begin
        if (csN) begin
            misoQ <= 1'b0;
        end else if (bitCntQ < 6'h08 || bitCntQ > 6'h1f) begin
            misoQ <= 1'b0;
        end else begin
            misoQ <= respQ[txIdx];
        end
    end
    assign miso = misoQ;

    ////////////////////////////////////////////////////////////////////////
    // Crossing: frame toggle into the system domain
    logic                  tglSync1Q;    // First stage only
    logic                  tglSync2Q;    // Safe copy
    logic                  tglSeenQ;     // Last toggle handled
    logic                  frameEvt;     // New frame pulse

    // Two-flop toggle synchroniser
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tglSync1Q <= 1'b0;
            tglSync2Q <= 1'b0;
            tglSeenQ  <= 1'b0;
        end else begin
            tglSync1Q <= frameTglQ;
            tglSync2Q <= tglSync1Q;
            tglSeenQ  <= tglSync2Q;
        end
    end
    assign frameEvt = tglSync2Q ^ tglSeenQ;

    ////////////////////////////////////////////////////////////////////////
    // Frame decode
    logic [ADDR_W-1:0]     cmdAddr;      // Addressed register
    logic                  cmdWrite;     // Write request
    logic [DATA_W-1:0]     cmdData;      // Write data
    logic                  wrStb;        // Write this cycle

    assign cmdAddr  = frameWordQ[ADDR_MSB:ADDR_LSB];
    assign cmdWrite = frameWordQ[RW_BIT];
    assign cmdData  = frameWordQ[DATA_W-1:0];
    assign wrStb    = frameEvt & cmdWrite;

    // Write hits one register address
    function automatic logic hit(input logic [ADDR_W-1:0] a);
        hit = wrStb && (cmdAddr == a);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    logic [PROG_N-1:0]     compProgQ, compProgD;   // Keepalive, prog
    logic [GND_N-1:0]      compGndQ,  compGndD;    // Keepalive, ground
    logic [PROG_N-1:0]     thrProgQ,  thrProgD;    // Threshold select, prog
    logic [GND_N-1:0]      thrGndQ,   thrGndD;     // Threshold select, ground

    // Next values; only channel bits are stored
    always_comb begin
        compProgD = hit(REG_COMP_PROG) ? cmdData[PROG_N-1:0] : compProgQ;
        compGndD  = hit(REG_COMP_GND)  ? cmdData[GND_N-1:0]  : compGndQ;
        thrProgD  = hit(REG_THR_PROG)  ? cmdData[PROG_N-1:0] : thrProgQ;
        thrGndD   = hit(REG_THR_GND)   ? cmdData[GND_N-1:0]  : thrGndQ;
    end

    // Registers are kept across sleep and wake
    always_ff @(posedge clk) begin
        if (!rstn) begin
            compProgQ <= REG_RESET[PROG_N-1:0];
            compGndQ  <= REG_RESET[GND_N-1:0];
            thrProgQ  <= REG_RESET[PROG_N-1:0];
            thrGndQ   <= REG_RESET[GND_N-1:0];
        end else begin
            compProgQ <= compProgD;
            compGndQ  <= compGndD;
            thrProgQ  <= thrProgD;
            thrGndQ   <= thrGndD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input level synchronisers
    logic [PROG_N-1:0]     progSync1Q, progSync2Q; // Prog levels
    logic [GND_N-1:0]      gndSync1Q,  gndSync2Q;  // Ground levels

    // Two flops per pin
    always_ff @(posedge clk) begin
        if (!rstn) begin
            progSync1Q <= '0;
            progSync2Q <= '0;
            gndSync1Q  <= '0;
            gndSync2Q  <= '0;
        end else begin
            progSync1Q <= progLevel;
            progSync2Q <= progSync1Q;
            gndSync1Q  <= gndLevel;
            gndSync2Q  <= gndSync1Q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sleep control
    lwc_mode_e             modeQ;        // Operating mode
    logic [15:0]           tickCntQ;     // Low-power clock divider
    logic                  tick;         // Low-power clock edge
    logic [PROG_N-1:0]     progRefQ;     // Prog levels at last tick
    logic [GND_N-1:0]      gndRefQ;      // Ground levels at last tick
    logic                  wake;         // Enabled change seen
    logic                  wakeReportQ;  // Next answer is the wake report

    assign tick = (tickCntQ == 16'(TICK_CYC - 1));
    assign wake = (modeQ == MODE_LOW) && tick &&
                  (|((progSync2Q ^ progRefQ) & progWakeEn) ||
                   |((gndSync2Q ^ gndRefQ) & gndWakeEn));

    // Divider runs only while asleep
    always_ff @(posedge clk) begin
        if (!rstn || modeQ != MODE_LOW || tick) begin
            tickCntQ <= 16'h0000;
        end else begin
            tickCntQ <= tickCntQ + 16'h0001;
        end
    end

    // Reference levels: taken at entry and at each tick
    always_ff @(posedge clk) begin
        if (!rstn) begin
            progRefQ <= '0;
            gndRefQ  <= '0;
        end else if (modeQ == MODE_NORMAL || tick) begin
            progRefQ <= progSync2Q;
            gndRefQ  <= gndSync2Q;
        end
    end

    // Mode machine: sleep only by command, wake on change
    always_ff @(posedge clk) begin
        if (!rstn) begin
            modeQ <= MODE_NORMAL;
        end else begin
            case (modeQ)
                MODE_NORMAL: begin
                    if (hit(REG_LPM_CMD)) begin
                        modeQ <= MODE_LOW;
                    end
                end
                MODE_LOW: begin
                    if (wake) begin
                        modeQ <= MODE_NORMAL;
                    end
                end
                default: modeQ <= MODE_NORMAL;
            endcase
        end
    end

    // Wake report flag; a wake in a frame cycle wins
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wakeReportQ <= 1'b0;
        end else if (wake) begin
            wakeReportQ <= 1'b1;
        end else if (frameEvt) begin
            wakeReportQ <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Answer word
    // Register read value, zero above the channel bits
    function automatic logic [RDATA_W-1:0] regRead(input logic [ADDR_W-1:0] a,
                                                   input logic [PROG_N-1:0] cp,
                                                   input logic [GND_N-1:0]  cg,
                                                   input logic [PROG_N-1:0] tp,
                                                   input logic [GND_N-1:0]  tg);
        regRead = '0;
        case (a)
            REG_COMP_PROG: regRead[PROG_N-1:0] = cp;
            REG_COMP_GND:  regRead[GND_N-1:0]  = cg;
            REG_THR_PROG:  regRead[PROG_N-1:0] = tp;
            REG_THR_GND:   regRead[GND_N-1:0]  = tg;
            default:       regRead = '0;
        endcase
    endfunction : regRead

    // Built per frame; stable through the next frame
    always_ff @(posedge clk) begin
        if (!rstn) begin
            respQ <= '0;
        end else if (frameEvt) begin
            if (wakeReportQ || wake) begin
                respQ <= {1'b1, 1'b1, gndSync2Q, progSync2Q};
            end else begin
                respQ <= {faultSummary, intFlag,
                          regRead(cmdAddr, compProgD, compGndD, thrProgD, thrGndD)};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Front-end control outputs
    // Comparators and polling current per channel
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lowPowerMode      <= 1'b0;
            progCompActive    <= '1;
            gndCompActive     <= '1;
            progPollCurrentEn <= '0;
            gndPollCurrentEn  <= '0;
        end else begin
            lowPowerMode      <= (modeQ == MODE_LOW);
            progCompActive    <= (modeQ == MODE_LOW) ? (compProgQ | {PROG_N{tick}}) : '1;
            gndCompActive     <= (modeQ == MODE_LOW) ? (compGndQ | {GND_N{tick}}) : '1;
            progPollCurrentEn <= (modeQ == MODE_LOW) ? ({PROG_N{tick}} & ~compProgQ) : '0;
            gndPollCurrentEn  <= (modeQ == MODE_LOW) ? ({GND_N{tick}} & ~compGndQ) : '0;
        end
    end

    // Threshold choice: one is normal, zero is delta
    always_ff @(posedge clk) begin
        if (!rstn) begin
            progThrNormal <= '1;
            gndThrNormal  <= '1;
        end else if (modeQ == MODE_LOW) begin
            progThrNormal <= thrProgQ | progIsBattery;
            gndThrNormal  <= thrGndQ;
        end else begin
            progThrNormal <= '1;
            gndThrNormal  <= '1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Write then settle
    sequence wrSeq(logic [6:0] a);
        wrStb && cmdAddr == a;
    endsequence

    AST_WR_COMP_PROG: assert property (wrSeq(REG_COMP_PROG) |=> compProgQ == $past(cmdData[PROG_N-1:0]))
        else $error("prog keepalive write lost");
    AST_WR_COMP_GND: assert property (wrSeq(REG_COMP_GND) |=> compGndQ == $past(cmdData[GND_N-1:0]))
        else $error("ground keepalive write lost");
    AST_WR_THR_PROG: assert property (wrSeq(REG_THR_PROG) |=> thrProgQ == $past(cmdData[PROG_N-1:0]))
        else $error("prog threshold write lost");
    AST_WR_THR_GND: assert property (wrSeq(REG_THR_GND) |=> thrGndQ == $past(cmdData[GND_N-1:0]))
        else $error("ground threshold write lost");
    AST_READ_KEEPS: assert property (frameEvt && !cmdWrite |=> $stable(compProgQ) && $stable(thrGndQ))
        else $error("read changed a register");
    AST_LPM_ENTRY: assert property (wrSeq(REG_LPM_CMD) ##0 modeQ == MODE_NORMAL |=> ##1 lowPowerMode)
        else $error("sleep command ignored");
    AST_NO_POLL_KEEPALIVE: assert property (modeQ == MODE_LOW |=> (progPollCurrentEn & $past(compProgQ)) == '0 &&
        (progCompActive & $past(compProgQ)) == $past(compProgQ))
        else $error("keepalive channel polled");
    AST_BATT_NORMAL: assert property (modeQ == MODE_LOW ##1 modeQ == MODE_LOW |=>
        (progThrNormal & $past(progIsBattery)) == $past(progIsBattery))
        else $error("battery channel on delta threshold");
    AST_WAKE_REPORT: assert property (frameEvt && (wakeReportQ || wake) |=> respQ[FAULT_BIT:INT_BIT] == 2'b11)
        else $error("wake report missing");
    AST_WAKE_GATED: assert property (modeQ == MODE_LOW && tick && ((progSync2Q ^ progRefQ) & progWakeEn) == '0 &&
        ((gndSync2Q ^ gndRefQ) & gndWakeEn) == '0 |=> modeQ == MODE_LOW)
        else $error("disabled channel woke device");
    AST_UNUSED_ZERO: assert property (frameEvt && !wakeReportQ && !wake && cmdAddr == REG_COMP_PROG
        |=> respQ[RDATA_W-1:PROG_N] == '0)
        else $error("unused bits read nonzero");
    AST_BITCNT_SAT: assert property (@(posedge sclk) disable iff (csN) bitCntQ <= 6'h20)
        else $error("bit counter overran");

endmodule : lwc_wake_config

// ---- core/lwc_pkg.sv ----
// Purpose: Shared constants for the low-power wake configuration bank
// Assumes: 32-bit frames, 24-bit register data, clk at 25 MHz
// Notes:   Offsets are 7-bit register addresses carried in frame bits 31..25
package lwc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Frame layout
    localparam int          FRAME_BITS    = 32;       // Bits per frame
    localparam int          ADDR_W        = 7;        // Register address width
    localparam int          DATA_W        = 24;       // Data field width
    localparam int          ADDR_MSB      = 31;       // Address top bit
    localparam int          ADDR_LSB      = 25;       // Address low bit
    localparam int          RW_BIT        = 24;       // Read/write flag
    localparam int          FAULT_BIT     = 23;       // Fault summary in answer
    localparam int          INT_BIT       = 22;       // Interrupt flag in answer
    localparam int          RDATA_W       = 22;       // Register data in answer
    localparam int          PAD_BITS      = 8;        // Leading answer bits, zero

    ////////////////////////////////////////////////////////////////////////
    // Register addresses
    localparam logic [6:0]  REG_COMP_PROG = 7'h12;    // Comparator keepalive, prog
    localparam logic [6:0]  REG_COMP_GND  = 7'h13;    // Comparator keepalive, ground
    localparam logic [6:0]  REG_THR_PROG  = 7'h14;    // Sleep threshold, prog
    localparam logic [6:0]  REG_THR_GND   = 7'h15;    // Sleep threshold, ground
    localparam logic [6:0]  REG_LPM_CMD   = 7'h1c;    // Enter low-power command

    ////////////////////////////////////////////////////////////////////////
    // Channel counts and reset values
    localparam int          PROG_CH       = 8;        // Programmable inputs
    localparam int          GND_CH        = 14;       // Ground-switch inputs
    localparam logic [23:0] REG_RESET     = 24'h000000; // All four registers

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int          CLK_PERIOD_NS = 40;       // System clock period
    localparam int          LPM_TICK_NS   = 1000;     // Low-power clock period
    localparam int          LPM_TICK_CYC  = (LPM_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // Operating modes
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b01,   // Normal operation
        MODE_LOW    = 2'b10    // Low-power mode
    } lwc_mode_e;

endpackage : lwc_pkg

// ---- tb/lwc_spi_master.sv ----
// Purpose: Behavioural SPI master that frames commands for the wake configuration bank
// Assumes: Mode 0, MSB first, 48 ns link clock, clock still low outside frames
// Notes:   The answer to a frame comes back during the following frame
`timescale 1ns/1ns
module lwc_spi_master (
    // SPI link
    output logic      sclk,
    output logic      csN,
    output logic      mosi,
    input  wire logic miso
);
    localparam int HALF_NS = 24;   // Half link clock period
    localparam int GAP_NS  = 400;  // Deselect gap, above the 240 ns minimum

    ////////////////////////////////////////////////////////////////////////
    // Idle link: deselected, clock standing still
    initial begin
        sclk <= 1'b0;
        csN  <= 1'b1;
        mosi <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One 32-bit frame out, previous answer in
    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        #7;                            // Off the system clock grid
        csN = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            mosi = tx[i];              // Address, flag, data, MSB first
            #HALF_NS;
            sclk = 1'b1;
            rx[i] = miso;              // Sampled on the rising edge
            #HALF_NS;
            sclk = 1'b0;
        end
        #HALF_NS;
        csN  = 1'b1;
        mosi = ~mosi;                  // Released line never shows the last bit
        #GAP_NS;
    endtask : xfer

endmodule : lwc_spi_master

// ---- tb/test_lwc_wake_config.sv ----
// Purpose: Self-checking bench for the wake configuration bank
// Assumes: Short low-power tick of 4 clocks
// Notes:   Each register access is its frame plus one fetch frame
`timescale 1ns/1ns
module test_lwc_wake_config import lwc_pkg::*; ();
    localparam int TICK = 4;                     // Cycles per low-power tick
    logic        clk, rstn, sclk, csN, mosi, miso, lowPowerMode, faultSummary, intFlag;
    logic [7:0]  progLevel, progIsBattery, progWakeEn, progCompActive, progPollCurrentEn, progThrNormal;
    logic [13:0] gndLevel, gndWakeEn, gndCompActive, gndPollCurrentEn, gndThrNormal;
    int          num_errors, check_count, n;
    logic [31:0] rsp;
    logic        seen;
    logic [6:0]  regA [4] = '{REG_COMP_PROG, REG_COMP_GND, REG_THR_PROG, REG_THR_GND};
    logic [21:0] regM [4] = '{22'h0000ff, 22'h003fff, 22'h0000ff, 22'h003fff};

    ////////////////////////////////////////////////////////////////////////
    // Design and link partner
    lwc_wake_config #(.TICK_CYC(TICK)) DUT (
        .clk(clk), .rstn(rstn), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso),
        .progLevel(progLevel), .gndLevel(gndLevel), .progIsBattery(progIsBattery),
        .progWakeEn(progWakeEn), .gndWakeEn(gndWakeEn), .faultSummary(faultSummary),
        .intFlag(intFlag), .lowPowerMode(lowPowerMode), .progCompActive(progCompActive),
        .gndCompActive(gndCompActive), .progPollCurrentEn(progPollCurrentEn),
        .gndPollCurrentEn(gndPollCurrentEn), .progThrNormal(progThrNormal), .gndThrNormal(gndThrNormal));
    lwc_spi_master MST (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso));

    ////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare and access tasks
    task automatic chk_rsp(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : chk_rsp

    task automatic chk_out(input logic [21:0] got, input logic [21:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : chk_out

    // Answer word: zero pad, fault, interrupt, data
    function automatic logic [31:0] ans(input logic f, input logic i, input logic [21:0] v);
        return {8'h00, f, i, v};
    endfunction : ans

    // Frame, then a fetch frame that carries its answer back
    task automatic access(input logic [6:0] a, input logic wr, input logic [23:0] d, output logic [31:0] r);
        logic [31:0] junk;
        MST.xfer({a, wr, d}, junk);
        MST.xfer(32'h00000000, r);
    endtask : access

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        #1_000_000;
        num_errors++;
        $display("unexpected at %0t: run hung", $time);
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    // Tests
    initial begin
        num_errors = 0;
        check_count = 0;
        rstn <= 1'b0;
        progLevel <= 8'h00;
        gndLevel <= 14'h0000;
        progIsBattery <= 8'h50;
        progWakeEn <= 8'hff;
        gndWakeEn <= 14'h3fdf;                   // Channel 5 may not wake
        faultSummary <= 1'b0;
        intFlag <= 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        MST.xfer(32'h00000000, rsp);             // Settles the link side

        // Reset values and normal-mode outputs
        for (int k = 0; k < 4; k++) begin
            access(regA[k], 1'b0, 24'h000000, rsp);
            chk_rsp(rsp, ans(1'b0, 1'b0, 22'h0), "reset value");
        end
        chk_out({gndCompActive, progCompActive}, 22'h3fffff, "normal comparators");
        chk_out({gndPollCurrentEn, progPollCurrentEn}, 22'h0, "normal polling");
        chk_out({gndThrNormal, progThrNormal}, 22'h3fffff, "normal thresholds");
        $display("test reset done");

        // Full writes, masked readback, reads leave registers alone
        @(posedge clk);
        faultSummary <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            access(regA[k], 1'b1, 24'hffffff, rsp);
            chk_rsp(rsp, ans(1'b1, 1'b0, regM[k]), "write all ones");
            access(regA[k], 1'b0, 24'h000000, rsp);
            chk_rsp(rsp, ans(1'b1, 1'b0, regM[k]), "read keeps value");
        end
        access(7'h7f, 1'b1, 24'hffffff, rsp);
        chk_rsp(rsp, ans(1'b1, 1'b0, 22'h0), "unmapped address");
        @(posedge clk);
        faultSummary <= 1'b0;
        intFlag <= 1'b1;
        access(REG_COMP_PROG, 1'b0, 24'h000000, rsp);
        chk_rsp(rsp, ans(1'b0, 1'b1, 22'h0000ff), "interrupt bit");
        $display("test access done");

        // Sleep with keepalive and threshold selections
        @(posedge clk);
        intFlag <= 1'b0;
        access(REG_COMP_PROG, 1'b1, 24'h00000f, rsp);
        access(REG_COMP_GND, 1'b1, 24'h000003, rsp);
        access(REG_THR_PROG, 1'b1, 24'h000033, rsp);
        access(REG_THR_GND, 1'b1, 24'h002aaa, rsp);
        access(REG_LPM_CMD, 1'b1, 24'h000000, rsp);
        repeat (10) @(posedge clk);
        chk_out({21'h0, lowPowerMode}, 22'h1, "asleep");
        chk_out({14'h0, progThrNormal}, 22'h000073, "prog thresholds");
        chk_out({8'h00, gndThrNormal}, 22'h002aaa, "ground thresholds");
        seen = 1'b0;
        repeat (3 * TICK) begin
            @(negedge clk);
            chk_out({gndPollCurrentEn & 14'h0003, progPollCurrentEn & 8'h0f}, 22'h0, "keepalive polling");
            chk_out({gndCompActive & 14'h0003, progCompActive & 8'h0f}, 22'h00030f, "keepalive comps");
            seen = seen | progPollCurrentEn[7];
        end
        chk_out({21'h0, seen}, 22'h1, "tick polling");

        // Driven inputs only; a disabled channel must not wake
        @(posedge clk);
        gndLevel <= 14'h0020;                    // Logic-driven input
        repeat (4 * TICK) @(posedge clk);
        chk_out({21'h0, lowPowerMode}, 22'h1, "disabled channel");
        progLevel <= 8'h04;
        for (n = 0; n < 4 * TICK + 8 && lowPowerMode !== 1'b0; n++) @(negedge clk);
        chk_out({21'h0, lowPowerMode}, 22'h0, "keepalive wake");
        access(REG_COMP_PROG, 1'b0, 24'h000000, rsp);
        chk_rsp(rsp, ans(1'b1, 1'b1, 22'h002004), "wake report");
        access(REG_THR_GND, 1'b0, 24'h000000, rsp);
        chk_rsp(rsp, ans(1'b0, 1'b0, 22'h002aaa), "retained");
        chk_out({gndThrNormal, progThrNormal}, 22'h3fffff, "awake thresholds");
        $display("test sleep done");
        print_verdict();
    end

endmodule : test_lwc_wake_config
